// [src/lcs_fifo.sv]
// synchronous valid/ready fifo for digitised pixels
`timescale 1ns/1ns
module lcs_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   // ****************************************************************
   // storage and pointers
   // ****************************************************************
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];       // word storage
   logic [AW:0] wr_ptr;                 // write pointer, extra wrap bit
   logic [AW:0] rd_ptr;                 // read pointer, extra wrap bit
   logic [AW:0] next_wr_ptr;
   logic [AW:0] next_rd_ptr;
   logic do_push;
   logic do_pop;
   logic next_in_ready;                 // not full after this edge
   logic next_out_valid;                // not empty after this edge
   logic [WIDTH-1:0] next_head;         // word at the head after this edge

   // ****************************************************************
   // status and next pointers
   // ****************************************************************
   // flags and head worked out ahead, so every output leaves a flip-flop
   always_comb begin
      do_push = in_valid && in_ready;
      do_pop = out_valid && out_ready;
      next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
      // full when pointers differ only in the wrap bit
      next_in_ready = (next_wr_ptr ^ next_rd_ptr) != {1'b1, {AW{1'b0}}};
      next_out_valid = next_wr_ptr != next_rd_ptr;
      // a word written this cycle into the head slot bypasses the array
      next_head = (do_push && next_rd_ptr[AW-1:0] == wr_ptr[AW-1:0]) ? in_data
         : mem[next_rd_ptr[AW-1:0]];
   end

   // pointer, flag and head registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         in_ready <= next_in_ready;
         out_valid <= next_out_valid;
         out_data <= next_head;
      end
   end

   // storage needs no reset, the pointers guard it
   always_ff @(posedge sys_clk) begin
      if (do_push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

endmodule // lcs_fifo

// [src/lcs_pkg.sv]
// shared constants and types for the linear ccd clock sequencer
package lcs_pkg;

   // ****************************************************************
   // clock and timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 20;           // sys_clk period, 50 mhz
   localparam int QUARTER_NS = 100;             // least time of one quarter pixel slot
   localparam int TG_STEP_NS = 1000;            // least time of each transfer gate step
   localparam int TIMER_W = 16;                 // width of the step timer
   // least times round up to whole cycles
   localparam logic [15:0] QUARTER_CYCLES =
      16'((QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] TG_STEP_CYCLES =
      16'((TG_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ****************************************************************
   // line geometry
   // ****************************************************************
   localparam int PIX_CNT_W = 12;               // pixel counter width
   localparam logic [11:0] LINE_PIXELS = 12'h8AE;  // 2222 register clocks per line
   localparam int INTEG_W = 24;                 // integration counter width

   // ****************************************************************
   // pixel slots: two pixels of four quarters each
   // ****************************************************************
   localparam logic [2:0] SLOT_FIRST = 3'h0;    // reset pulse of a pixel
   localparam logic [1:0] QTR_SAMPLE = 2'h1;    // quarter in which the afe samples
   localparam logic [1:0] QTR_LAST = 2'h3;      // last quarter, phase two falls after it
   localparam logic [2:0] SLOT_LAST = 3'h7;     // last slot of a summed pair
   localparam logic [2:0] SLOT_SUM_RESET = 3'h4; // chroma reset slot when summing
   localparam logic [2:0] SLOT_SUM_LOW = 3'h6;  // summing gate low from here (25 %)

   // ****************************************************************
   // data path
   // ****************************************************************
   localparam int PIX_W = 16;                   // digitised pixel width
   localparam int FIFO_DEPTH = 32;              // words buffered toward the user

   // ****************************************************************
   // sequencer states
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_READOUT,
      ST_PARK,
      ST_TG_ON,
      ST_TG1_OFF,
      ST_TG2_OFF
   } lcs_state_t;

endpackage

// [src/lcs_sequencer.sv]
// clock sequencer driving a four channel linear ccd and buffering its samples
`timescale 1ns/1ns
module lcs_sequencer (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // control
   input wire logic run,
   input wire logic sum_enable,
   input wire logic chroma_enable,
   input wire logic luma_enable,
   input wire logic [lcs_pkg::INTEG_W-1:0] integ_cycles,
   // chroma sensor clocks
   output logic chroma_phase_one_clk,
   output logic chroma_phase_two_clk,
   output logic chroma_summing_gate_clk,
   output logic chroma_diffusion_reset_clk,
   output logic chroma_transfer_gate_one_clk,
   output logic chroma_transfer_gate_two_clk,
   // luma sensor clocks
   output logic luma_phase_one_clk,
   output logic luma_phase_two_clk,
   output logic luma_diffusion_reset_clk,
   output logic luma_transfer_gate_clk,
   // analog front end
   output logic afe_sample,
   input wire logic [lcs_pkg::PIX_W-1:0] afe_data,
   output logic line_start,
   // pixel stream toward the user
   output logic pix_valid,
   input wire logic pix_ready,
   output logic [lcs_pkg::PIX_W-1:0] pix_data
);

   // ****************************************************************
   // state
   // ****************************************************************
   lcs_pkg::lcs_state_t state;           // sequencer state
   lcs_pkg::lcs_state_t next_state;
   logic [lcs_pkg::TIMER_W-1:0] timer;    // counts down within a slot or step
   logic [lcs_pkg::TIMER_W-1:0] next_timer;
   logic [2:0] slot;                      // quarter slot within a pixel pair
   logic [2:0] next_slot;
   logic [lcs_pkg::PIX_CNT_W-1:0] pix_cnt; // pixels clocked this line
   logic [lcs_pkg::PIX_CNT_W-1:0] next_pix_cnt;
   logic [lcs_pkg::INTEG_W-1:0] integ_cnt; // cycles since integration began
   logic [lcs_pkg::INTEG_W-1:0] next_integ_cnt;
   logic [9:0] next_pins;                 // next sensor clock levels
   logic next_afe_sample;
   logic next_line_start;
   logic push_valid;                      // sample word offered to the fifo
   logic push_ready;                      // fifo can take it
   logic [lcs_pkg::PIX_W-1:0] push_data;
   logic [lcs_pkg::PIX_W-1:0] next_push_data;
   logic next_push_valid;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // phase one level for a slot; phase two is always its inverse
   function automatic logic phase_one(input logic [2:0] s);
      phase_one = !s[1];
   endfunction

   // chroma summing gate level for a slot and mode
   function automatic logic sum_gate(input logic [2:0] s, input logic summing);
      if (summing) begin
         sum_gate = s < lcs_pkg::SLOT_SUM_LOW;
      end else begin
         sum_gate = !phase_one(s);
      end
   endfunction

   // ****************************************************************
   // sequencing
   // ****************************************************************
   logic timer_done;
   logic integ_done;
   logic line_done;
   logic stall;
   always_comb begin
      timer_done = timer == '0;
      integ_done = integ_cnt >= integ_cycles;
      line_done = pix_cnt >= lcs_pkg::LINE_PIXELS;
      // hold the register when the fifo is full, so no sample is lost
      stall = (slot[1:0] == lcs_pkg::QTR_SAMPLE) && !line_done
         && push_valid && !push_ready;
      next_state = state;
      next_timer = timer_done ? '0 : timer - 1'b1;
      next_slot = slot;
      next_pix_cnt = pix_cnt;
      next_integ_cnt = (integ_cnt == '1) ? integ_cnt : integ_cnt + 1'b1;
      next_afe_sample = 1'b0;
      next_line_start = 1'b0;
      next_push_valid = push_valid && !push_ready;
      next_push_data = push_data;
      unique case (state)
         lcs_pkg::ST_IDLE: begin
            next_integ_cnt = '0;
            if (run) begin
               next_state = lcs_pkg::ST_READOUT;
               next_timer = lcs_pkg::QUARTER_CYCLES - 1'b1;
               next_slot = lcs_pkg::SLOT_FIRST;
               next_pix_cnt = '0;
            end
         end
         lcs_pkg::ST_READOUT: begin
            if (timer_done && !stall) begin
               next_timer = lcs_pkg::QUARTER_CYCLES - 1'b1;
               next_slot = slot + 1'b1;
               // afe samples the settled level, after reset, phase two low
               if (slot[1:0] == lcs_pkg::QTR_SAMPLE && !line_done) begin
                  next_afe_sample = 1'b1;
                  next_push_valid = 1'b1;
                  next_push_data = afe_data;
               end
               if (slot[1:0] == lcs_pkg::QTR_LAST && !line_done) begin
                  next_pix_cnt = pix_cnt + 1'b1;
               end
               // end the line only on a pair boundary so summing stays aligned
               if (slot == lcs_pkg::SLOT_LAST && line_done && integ_done) begin
                  next_state = lcs_pkg::ST_PARK;
                  next_timer = lcs_pkg::TG_STEP_CYCLES - 1'b1;
               end
               if (!run && slot == lcs_pkg::SLOT_LAST) begin
                  next_state = lcs_pkg::ST_IDLE;
               end
            end
         end
         lcs_pkg::ST_PARK: begin
            next_integ_cnt = '0;                  // next line starts integrating
            if (timer_done) begin
               next_state = lcs_pkg::ST_TG_ON;
               next_timer = lcs_pkg::TG_STEP_CYCLES - 1'b1;
            end
         end
         lcs_pkg::ST_TG_ON: begin
            if (timer_done) begin
               next_state = lcs_pkg::ST_TG1_OFF;
               next_timer = lcs_pkg::TG_STEP_CYCLES - 1'b1;
            end
         end
         lcs_pkg::ST_TG1_OFF: begin
            if (timer_done) begin
               next_state = lcs_pkg::ST_TG2_OFF;
               next_timer = lcs_pkg::TG_STEP_CYCLES - 1'b1;
            end
         end
         lcs_pkg::ST_TG2_OFF: begin
            if (timer_done) begin
               next_state = lcs_pkg::ST_READOUT;
               next_timer = lcs_pkg::QUARTER_CYCLES - 1'b1;
               next_slot = lcs_pkg::SLOT_FIRST;
               next_pix_cnt = '0;
               next_line_start = 1'b1;
            end
         end
      endcase
   end

   // ****************************************************************
   // sensor pin levels, worked out from the next state
   // ****************************************************************
   // order: c_p1 c_p2 c_sum c_rst c_tg1 c_tg2 l_p1 l_p2 l_rst l_tg
   logic c_p1, c_sum, c_rst, c_tg1, c_tg2, l_p1, l_rst, l_tg;
   always_comb begin
      // parked levels: phase one high, phase two low, gates at barrier
      c_p1 = 1'b1;
      l_p1 = 1'b1;
      c_sum = 1'b0;
      c_rst = 1'b1;
      l_rst = 1'b1;
      c_tg1 = 1'b0;
      c_tg2 = 1'b0;
      l_tg = 1'b0;
      unique case (next_state)
         lcs_pkg::ST_READOUT: begin
            // one slot counter drives both sets together
            c_p1 = phase_one(next_slot);
            l_p1 = phase_one(next_slot);
            // phase two falls after the last quarter, dumping into the node
            c_sum = sum_enable ? sum_gate(next_slot, 1'b1)
               : sum_gate(next_slot, 1'b0);
            l_rst = next_slot[1:0] == lcs_pkg::SLOT_FIRST[1:0];
            c_rst = sum_enable ? (next_slot == lcs_pkg::SLOT_SUM_RESET)
               : l_rst;
         end
         lcs_pkg::ST_TG_ON: begin
            c_tg1 = 1'b1;
            c_tg2 = 1'b1;
            l_tg = 1'b1;
         end
         lcs_pkg::ST_TG1_OFF: begin
            c_tg2 = 1'b1;
         end
         default: begin
         end
      endcase
      // a disabled set stays parked and isolated
      if (!chroma_enable) begin
         c_p1 = 1'b1;
         c_sum = 1'b0;
         c_rst = 1'b1;
         c_tg1 = 1'b0;
         c_tg2 = 1'b0;
      end
      if (!luma_enable) begin
         l_p1 = 1'b1;
         l_rst = 1'b1;
         l_tg = 1'b0;
      end
      next_pins = {c_p1, !c_p1, c_sum, c_rst, c_tg1, c_tg2, l_p1, !l_p1, l_rst, l_tg};
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   // every sensor pin comes straight from a flip-flop to avoid glitches
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= lcs_pkg::ST_IDLE;
         timer <= '0;
         slot <= 3'h0;
         pix_cnt <= '0;
         integ_cnt <= '0;
         afe_sample <= 1'b0;
         line_start <= 1'b0;
         push_valid <= 1'b0;
         push_data <= '0;
         {chroma_phase_one_clk, chroma_phase_two_clk, chroma_summing_gate_clk,
          chroma_diffusion_reset_clk, chroma_transfer_gate_one_clk,
          chroma_transfer_gate_two_clk, luma_phase_one_clk, luma_phase_two_clk,
          luma_diffusion_reset_clk, luma_transfer_gate_clk} <= 10'h24A;  // parked
      end else begin
         state <= next_state;
         timer <= next_timer;
         slot <= next_slot;
         pix_cnt <= next_pix_cnt;
         integ_cnt <= next_integ_cnt;
         afe_sample <= next_afe_sample;
         line_start <= next_line_start;
         push_valid <= next_push_valid;
         push_data <= next_push_data;
         {chroma_phase_one_clk, chroma_phase_two_clk, chroma_summing_gate_clk,
          chroma_diffusion_reset_clk, chroma_transfer_gate_one_clk,
          chroma_transfer_gate_two_clk, luma_phase_one_clk, luma_phase_two_clk,
          luma_diffusion_reset_clk, luma_transfer_gate_clk} <= next_pins;
      end
   end

   // ****************************************************************
   // sample buffer toward the user
   // ****************************************************************
   // a full fifo stalls the register clocks instead of dropping pixels
   lcs_fifo #(
      .WIDTH(lcs_pkg::PIX_W),
      .DEPTH(lcs_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_data),
      .out_valid(pix_valid),
      .out_ready(pix_ready),
      .out_data(pix_data)
   );

endmodule // lcs_sequencer

// [tb/lcs_ccd_model.sv]
// behavioural model of the four channel ccd and its front end digitiser
`timescale 1ns/1ns
module lcs_ccd_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // chroma clocks
   input wire logic chroma_phase_two_clk,
   input wire logic chroma_summing_gate_clk,
   input wire logic chroma_transfer_gate_two_clk,
   // luma clocks
   input wire logic luma_phase_two_clk,
   input wire logic luma_transfer_gate_clk,
   // digitised video toward the sequencer
   output logic [lcs_pkg::PIX_W-1:0] afe_data
);
   logic [15:0] luma_pkt; // packets moved to the luma sense node
   logic [15:0] chroma_pkt; // chroma packets, counted on phase two fall only with the summing gate low
   logic l2_q; // luma phase two, one cycle late
   logic c2_q; // chroma phase two, one cycle late
   // shift registers: one phase pair moves every channel at once
   always_ff @(posedge sys_clk) begin
      l2_q <= luma_phase_two_clk;
      c2_q <= chroma_phase_two_clk;
      if (rst || luma_transfer_gate_clk) begin
         luma_pkt <= 16'h0000; // single gate pulse loads a fresh line
      end else if (l2_q && !luma_phase_two_clk) begin
         luma_pkt <= luma_pkt + 16'h0001; // packet lands on phase two fall
      end
      if (rst || chroma_transfer_gate_two_clk) begin
         chroma_pkt <= 16'h0000;
      end else if (c2_q && !chroma_phase_two_clk && !chroma_summing_gate_clk) begin
         chroma_pkt <= chroma_pkt + 16'h0001; // summing gate merges pairs
      end
   end
   // value only valid while phase two is low, garbage otherwise
   assign afe_data = luma_phase_two_clk ? ~luma_pkt : luma_pkt;
endmodule // lcs_ccd_model

// [tb/lcs_chk.sv]
// assertion checker for the ccd clock sequencer pins
`timescale 1ns/1ns
module lcs_chk (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // control
   input wire logic sum_enable,
   // chroma clocks
   input wire logic chroma_phase_one_clk,
   input wire logic chroma_phase_two_clk,
   input wire logic chroma_summing_gate_clk,
   input wire logic chroma_diffusion_reset_clk,
   input wire logic chroma_transfer_gate_one_clk,
   input wire logic chroma_transfer_gate_two_clk,
   // luma clocks
   input wire logic luma_phase_one_clk,
   input wire logic luma_phase_two_clk,
   input wire logic luma_diffusion_reset_clk,
   input wire logic luma_transfer_gate_clk,
   // front end and framing
   input wire logic afe_sample,
   input wire logic line_start
);
   logic [7:0] park_cnt; // cycles with phases parked
   logic [7:0] sum_cnt; // cycles with summing asked
   logic [7:0] full_cnt; // cycles with full resolution asked
   // saturating, so long idle spans never wrap round
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         park_cnt <= 8'h00;
         sum_cnt <= 8'h00;
         full_cnt <= 8'h00;
      end else begin
         park_cnt <= (chroma_phase_one_clk && !chroma_phase_two_clk) ?
            park_cnt + {7'h00, park_cnt != 8'hFF} : 8'h00;
         sum_cnt <= sum_enable ? sum_cnt + {7'h00, sum_cnt != 8'hFF} : 8'h00;
         full_cnt <= !sum_enable ? full_cnt + {7'h00, full_cnt != 8'hFF} : 8'h00;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ********
   // assertions
   // ********
   phase_compl_a: assert property (
      chroma_phase_one_clk != chroma_phase_two_clk && luma_phase_one_clk != luma_phase_two_clk)
      else $error("phase clocks not complementary");
   gate_parked_a: assert property (
      chroma_transfer_gate_one_clk |->
      chroma_phase_one_clk && !chroma_phase_two_clk && park_cnt >= 8'h28)
      else $error("transfer gate open without parked phases");
   tg_one_width_a: assert property (
      $rose(chroma_transfer_gate_one_clk) |->
      ##49 chroma_transfer_gate_one_clk ##1 !chroma_transfer_gate_one_clk)
      else $error("first chroma gate step length wrong");
   tg_two_hold_a: assert property (
      $fell(chroma_transfer_gate_one_clk) |-> chroma_transfer_gate_two_clk
      ##49 chroma_transfer_gate_two_clk ##1 !chroma_transfer_gate_two_clk)
      else $error("second chroma gate order wrong");
   luma_once_a: assert property (
      $rose(luma_transfer_gate_clk) |->
      ##49 luma_transfer_gate_clk ##1 (!luma_transfer_gate_clk)[*8])
      else $error("luma gate pulse wrong");
   readout_resume_a: assert property (
      $fell(chroma_transfer_gate_two_clk) |-> ##[45:55] line_start)
      else $error("readout did not resume");
   // a mode change in mid-pattern breaks it while the slots count on, so leaving summing aborts the attempt
   sum_duty_a: assert property (
      disable iff (rst || !sum_enable)
      $rose(chroma_summing_gate_clk) && sum_cnt == 8'hFF |-> ##29 chroma_summing_gate_clk
      ##1 !chroma_summing_gate_clk ##9 !chroma_summing_gate_clk ##1 chroma_summing_gate_clk)
      else $error("summing gate duty wrong");
   // summed pair: chroma reset rises with the gate high only if the gate was already high the cycle before
   sum_reset_a: assert property (
      $rose(chroma_diffusion_reset_clk) && chroma_summing_gate_clk && sum_cnt == 8'hFF
      |-> $past(chroma_summing_gate_clk))
      else $error("chroma reset not on summed pair");
   full_res_a: assert property (
      full_cnt == 8'hFF |-> chroma_summing_gate_clk == chroma_phase_two_clk)
      else $error("summing gate not following phase two");
   sample_low_a: assert property (
      afe_sample |-> !$past(luma_phase_two_clk))
      else $error("sample taken with phase two high");
   reset_first_a: assert property (
      $fell(luma_phase_two_clk) |-> luma_diffusion_reset_clk)
      else $error("no reset pulse at pixel start");
   // main scenarios
   cov_sum: cover property ($rose(chroma_summing_gate_clk) && sum_cnt == 8'hFF);
   cov_tg: cover property ($rose(chroma_transfer_gate_one_clk));
   cov_line: cover property (line_start);
endmodule // lcs_chk
bind lcs_sequencer lcs_chk u_chk (.sys_clk, .rst, .sum_enable, .chroma_phase_one_clk,
   .chroma_phase_two_clk, .chroma_summing_gate_clk, .chroma_diffusion_reset_clk,
   .chroma_transfer_gate_one_clk,
   .chroma_transfer_gate_two_clk, .luma_phase_one_clk, .luma_phase_two_clk,
   .luma_diffusion_reset_clk, .luma_transfer_gate_clk, .afe_sample, .line_start);

// [tb/tb.sv]
// self-checking bench for the ccd clock sequencer
`timescale 1ns/1ns
module tb;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic run = 1'b0;
   logic sum_enable = 1'b0;
   logic chroma_enable = 1'b1;
   logic luma_enable = 1'b1;
   logic [lcs_pkg::INTEG_W-1:0] integ_cycles = 24'h000064; // short, line length rules
   logic chroma_phase_one_clk, chroma_phase_two_clk, chroma_summing_gate_clk;
   logic chroma_diffusion_reset_clk, chroma_transfer_gate_one_clk, chroma_transfer_gate_two_clk;
   logic luma_phase_one_clk, luma_phase_two_clk, luma_diffusion_reset_clk, luma_transfer_gate_clk;
   logic afe_sample, line_start, pix_valid;
   logic pix_ready = 1'b0;
   logic [lcs_pkg::PIX_W-1:0] afe_data, pix_data;
   int error_cnt = 0;
   int num_checks = 0;
   int n_samp; // samples in the current line
   logic [15:0] exp_word; // next word due at the stream
   always #10 sys_clk = ~sys_clk;
   lcs_sequencer u_dut (.sys_clk, .rst, .run, .sum_enable, .chroma_enable, .luma_enable,
      .integ_cycles, .chroma_phase_one_clk, .chroma_phase_two_clk, .chroma_summing_gate_clk,
      .chroma_diffusion_reset_clk, .chroma_transfer_gate_one_clk, .chroma_transfer_gate_two_clk,
      .luma_phase_one_clk, .luma_phase_two_clk, .luma_diffusion_reset_clk,
      .luma_transfer_gate_clk, .afe_sample, .afe_data, .line_start, .pix_valid, .pix_ready,
      .pix_data);
   lcs_ccd_model u_ccd (.sys_clk, .rst, .chroma_phase_two_clk, .chroma_summing_gate_clk,
      .chroma_transfer_gate_two_clk, .luma_phase_two_clk, .luma_transfer_gate_clk, .afe_data);
   // ********
   // shared tasks
   // ********
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // one cycle: count samples, pop and compare the stream
   task automatic step;
      @(posedge sys_clk);
      if (afe_sample === 1'b1) n_samp++;
      if (pix_valid === 1'b1 && pix_ready) begin
         chk(pix_data, exp_word);
         exp_word++;
      end
   endtask
   // ********
   // scenarios
   // ********
   // pins parked after reset, gates at barrier while idle
   task automatic t_reset;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (30) @(posedge sys_clk);
      chk({6'h00, chroma_phase_one_clk, chroma_phase_two_clk, chroma_summing_gate_clk,
         chroma_diffusion_reset_clk, chroma_transfer_gate_one_clk, chroma_transfer_gate_two_clk,
         luma_phase_one_clk, luma_phase_two_clk, luma_diffusion_reset_clk,
         luma_transfer_gate_clk}, 16'h024A);
   endtask
   // stream stalled: fifo fills, readout freezes
   task automatic t_fill;
      int gap;
      logic [3:0] pins;
      n_samp = 0;
      gap = 0;
      exp_word = 16'h0000;
      run <= 1'b1;
      while (gap < 100 && n_samp < 40) begin
         step();
         gap = (afe_sample === 1'b1) ? 0 : gap + 1;
      end
      chk({15'h0000, n_samp == 32 || n_samp == 33}, 16'h0001);
      pins = {chroma_phase_two_clk, chroma_summing_gate_clk, luma_phase_two_clk, pix_valid};
      repeat (40) step();
      chk({12'h000, chroma_phase_two_clk, chroma_summing_gate_clk, luma_phase_two_clk,
         pix_valid}, {12'h000, pins});
      chk({15'h0000, pix_valid}, 16'h0001);
   endtask
   // drain a whole line with summing for a while, then check the transfer
   task automatic t_line;
      int i;
      int cnt;
      pix_ready <= 1'b1;
      for (i = 0; i < 46000 && chroma_transfer_gate_one_clk !== 1'b1; i++) begin
         step();
         sum_enable <= (n_samp >= 400 && n_samp < 800);
      end
      chk(16'(n_samp), {4'h0, lcs_pkg::LINE_PIXELS});
      chk({13'h0000, chroma_phase_one_clk, chroma_phase_two_clk, luma_transfer_gate_clk},
         16'h0005);
      for (cnt = 0; chroma_transfer_gate_one_clk === 1'b1 && cnt < 200; cnt++) step();
      chk(16'(cnt), 16'h0032);
      chk({14'h0000, chroma_transfer_gate_two_clk, luma_transfer_gate_clk}, 16'h0002);
      for (cnt = 0; chroma_transfer_gate_two_clk === 1'b1 && cnt < 200; cnt++) step();
      chk(16'(cnt), 16'h0032);
      for (cnt = 0; line_start !== 1'b1 && cnt < 200; cnt++) step();
      chk({15'h0000, line_start}, 16'h0001);
      exp_word = 16'h0000;
   endtask
   // chroma parked while luma reads on, then stop
   task automatic t_second;
      int i;
      int c_hi;
      int l_rise;
      logic l_q;
      c_hi = 0;
      l_rise = 0;
      l_q = luma_phase_two_clk;
      chroma_enable <= 1'b0;
      for (i = 0; i < 300; i++) begin
         step();
         if (i >= 50 && chroma_phase_two_clk !== 1'b0) c_hi++;
         if (!l_q && luma_phase_two_clk) l_rise++;
         l_q = luma_phase_two_clk;
      end
      chk(16'(c_hi), 16'h0000);
      chk({15'h0000, l_rise > 8}, 16'h0001);
      chroma_enable <= 1'b1;
      run <= 1'b0;
      repeat (100) step();
      n_samp = 0;
      for (i = 0; i < 100; i++) begin
         step();
         if (chroma_transfer_gate_one_clk !== 1'b0) n_samp++;
      end
      chk(16'(n_samp), 16'h0000);
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      t_reset();
      t_fill();
      t_line();
      t_second();
      report_and_stop();
   end
endmodule // tb
